// >>> logic/pmem_pkg.sv
// Purpose: Constants and carriers for the program memory map block
// Assumes: 16 KB array, byte wide, one system clock
// Notes: Part identifier text is arbitrary and neutral
package pmem_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned ARRAY_AW = 14;
  localparam int unsigned ARRAY_BYTES = 16384;
  localparam int unsigned PAGE_AW = 9;
  localparam int unsigned PAGE_W = ARRAY_AW - PAGE_AW;
  localparam int unsigned SECTOR_W = 3;
  localparam int unsigned NUM_SECTORS = 8;
  localparam int unsigned INFO_BYTES = 512;
  localparam logic [15:0] INFO_BASE = 16'hfe00;
  localparam logic [15:0] PART_ID_FIRST = 16'hfe40;
  localparam logic [15:0] PART_ID_LAST = 16'hfe53;
  localparam int unsigned INFO_ENABLE_BIT = 7;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
  localparam logic [7:0] SECT_PROT_RESET = 8'h00;
  localparam logic [7:0] RESERVED_INFO = 8'h00;
  // Arbitrary neutral identifier, 20 characters, zero padded
  localparam logic [159:0] PART_ID_TEXT = {"PMEM16K", {13{8'h00}}};

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef enum logic [1:0] {
    ACC_FETCH = 2'b00,
    ACC_LOAD = 2'b01,
    ACC_WRITE = 2'b10,
    ACC_ERASE = 2'b11
  } acc_kind_t;

  typedef struct packed {
    logic valid;
    acc_kind_t kind;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
    logic from_info;
    logic refused;
  } mem_rsp_t;
endpackage

// >>> logic/program_memory_map.sv
// Purpose: Decode and steer program memory accesses, info overlay
// Assumes: Unlock sequencing and timing done by an outer controller
// Notes: Answer one cycle after each request
`timescale 1ns/10ps
module program_memory_map (
  input wire logic clk,
  input wire logic srst,
  input wire pmem_pkg::mem_req_t req,
  input wire logic dbg_sel,
  input wire logic unlocked,
  input wire logic [7:0] page_sel,
  input wire logic [7:0] sect_prot,
  output pmem_pkg::mem_rsp_t rsp,
  output logic [2:0] sector_idx,
  output logic info_en
);
  // ----------------------------------------
  // Storage and helpers
  // ----------------------------------------
  logic [7:0] array_q [pmem_pkg::ARRAY_BYTES];
  logic [7:0] sect_prot_q;
  logic [7:0] page_sel_q;

  function automatic logic [2:0] sector_of(input logic [15:0] a);
    return a[pmem_pkg::ARRAY_AW-1 -: pmem_pkg::SECTOR_W];
  endfunction

  function automatic logic in_info(input logic [15:0] a);
    return a >= pmem_pkg::INFO_BASE;
  endfunction

  function automatic logic [7:0] info_byte(input logic [15:0] a);
    logic [7:0] b;
    logic [4:0] k;
    b = pmem_pkg::RESERVED_INFO;
    k = 5'(a - pmem_pkg::PART_ID_FIRST);
    if (a >= pmem_pkg::PART_ID_FIRST && a <= pmem_pkg::PART_ID_LAST) begin
      b = pmem_pkg::PART_ID_TEXT[159 - 8*k -: 8];
    end
    return b;
  endfunction

  logic [2:0] req_sector;
  logic [13:0] aidx;
  logic overlay_hit;
  logic may_modify;
  assign req_sector = sector_of(req.addr);
  assign aidx = req.addr[pmem_pkg::ARRAY_AW-1:0];
  // Loads only; fetches never see the overlay
  assign overlay_hit = page_sel_q[pmem_pkg::INFO_ENABLE_BIT] && in_info(req.addr)
                       && req.kind == pmem_pkg::ACC_LOAD;
  // Writes aimed at the overlay are dropped, not redirected to the array
  assign may_modify = unlocked && !sect_prot_q[req_sector]
                      && !(page_sel_q[pmem_pkg::INFO_ENABLE_BIT] && in_info(req.addr))
                      && req.addr < 16'(pmem_pkg::ARRAY_BYTES);

  // ----------------------------------------
  // Control snapshots
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      page_sel_q <= pmem_pkg::PAGE_SEL_RESET;
      sect_prot_q <= pmem_pkg::SECT_PROT_RESET;
    end else begin
      page_sel_q <= page_sel;
      sect_prot_q <= sect_prot;
    end
  end

  // ----------------------------------------
  // Array program and erase
  // ----------------------------------------
  // Program only clears bits; erase needs a page
  always_ff @(posedge clk) begin
    if (req.valid && may_modify && req.kind == pmem_pkg::ACC_WRITE) begin
      array_q[aidx] <= array_q[aidx] & req.wdata;
    end else if (req.valid && may_modify && req.kind == pmem_pkg::ACC_ERASE) begin
      for (int i = 0; i < (1 << pmem_pkg::PAGE_AW); i++) begin
        array_q[{aidx[13:9], 9'(i)}] <= pmem_pkg::ERASED_BYTE;
      end
    end
  end

  // ----------------------------------------
  // Read steering
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp <= '0;
      sector_idx <= '0;
      info_en <= 1'b0;
    end else begin
      rsp.valid <= req.valid;
      rsp.from_info <= req.valid && overlay_hit;
      rsp.refused <= req.valid && (req.kind == pmem_pkg::ACC_WRITE
                     || req.kind == pmem_pkg::ACC_ERASE) && !may_modify;
      if (overlay_hit) begin
        rsp.rdata <= info_byte(req.addr);
      end else if (req.addr < 16'(pmem_pkg::ARRAY_BYTES)) begin
        rsp.rdata <= array_q[aidx];
      end else begin
        rsp.rdata <= pmem_pkg::ERASED_BYTE;
      end
      sector_idx <= req_sector;
      info_en <= page_sel_q[pmem_pkg::INFO_ENABLE_BIT];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Overlay is keyed to the snapshot, not the live page select
  sequence s_info_load;
    req.valid && req.kind == pmem_pkg::ACC_LOAD
    && page_sel_q[pmem_pkg::INFO_ENABLE_BIT] && req.addr >= pmem_pkg::INFO_BASE;
  endsequence

  sequence s_program;
    req.valid && req.kind == pmem_pkg::ACC_WRITE && may_modify;
  endsequence

  sequence s_readback;
    req.valid && req.kind == pmem_pkg::ACC_LOAD && !page_sel_q[pmem_pkg::INFO_ENABLE_BIT];
  endsequence

  // ----------------------------------------
  // Answer timing
  // ----------------------------------------
  chk_answer_follows: assert property (@(posedge clk) disable iff (srst)
    1'b1 |=> rsp.valid == $past(req.valid))
    else $error("answer strobe not one cycle after request");

  chk_refused_idle: assert property (@(posedge clk) disable iff (srst)
    !req.valid |=> !rsp.refused && !rsp.from_info)
    else $error("refusal or info flag without request");

  chk_sector_index: assert property (@(posedge clk) disable iff (srst)
    1'b1 |=> sector_idx == $past(req.addr[pmem_pkg::ARRAY_AW-1 -: pmem_pkg::SECTOR_W]))
    else $error("sector index wrong");

  chk_info_en_track: assert property (@(posedge clk) disable iff (srst)
    1'b1 |=> info_en == $past(page_sel_q[pmem_pkg::INFO_ENABLE_BIT]))
    else $error("info enable flag out of step");

  // ----------------------------------------
  // Overlay
  // ----------------------------------------
  chk_info_overlay_load: assert property (@(posedge clk) disable iff (srst)
    s_info_load |=> rsp.from_info && rsp.valid)
    else $error("info load not served from info area");

  chk_fetch_from_array: assert property (@(posedge clk) disable iff (srst)
    req.valid && req.kind == pmem_pkg::ACC_FETCH |=> !rsp.from_info)
    else $error("fetch served from info area");

  chk_disabled_no_overlay: assert property (@(posedge clk) disable iff (srst)
    !page_sel_q[pmem_pkg::INFO_ENABLE_BIT] |=> !rsp.from_info)
    else $error("overlay while disabled");

  chk_fetch_high_erased: assert property (@(posedge clk) disable iff (srst)
    req.valid && req.kind == pmem_pkg::ACC_FETCH && req.addr >= 16'(pmem_pkg::ARRAY_BYTES)
    |=> rsp.rdata == pmem_pkg::ERASED_BYTE)
    else $error("fetch beyond array not at erased level");

  chk_part_id_first: assert property (@(posedge clk) disable iff (srst)
    (s_info_load and req.addr == pmem_pkg::PART_ID_FIRST)
    |=> rsp.rdata == pmem_pkg::PART_ID_TEXT[159:152])
    else $error("part identifier first character wrong");

  chk_part_id_pad: assert property (@(posedge clk) disable iff (srst)
    (s_info_load and req.addr > pmem_pkg::PART_ID_LAST)
    |=> rsp.rdata == pmem_pkg::RESERVED_INFO)
    else $error("reserved info byte not zero");

  chk_reserved_low: assert property (@(posedge clk) disable iff (srst)
    (s_info_load and req.addr < pmem_pkg::PART_ID_FIRST)
    |=> rsp.rdata == pmem_pkg::RESERVED_INFO)
    else $error("reserved info byte below identifier not zero");

  // ----------------------------------------
  // Protection
  // ----------------------------------------
  chk_info_write_refused: assert property (@(posedge clk) disable iff (srst)
    req.valid && req.kind == pmem_pkg::ACC_WRITE && page_sel_q[pmem_pkg::INFO_ENABLE_BIT]
    && req.addr >= pmem_pkg::INFO_BASE |=> rsp.refused)
    else $error("info write accepted");

  chk_protected_refused: assert property (@(posedge clk) disable iff (srst)
    req.valid && req.kind == pmem_pkg::ACC_ERASE && sect_prot_q[sector_of(req.addr)]
    |=> rsp.refused)
    else $error("protected sector erase accepted");

  chk_prot_write_refused: assert property (@(posedge clk) disable iff (srst)
    req.valid && req.kind == pmem_pkg::ACC_WRITE && sect_prot_q[sector_of(req.addr)]
    |=> rsp.refused)
    else $error("protected sector write accepted");

  chk_unlocked_needed: assert property (@(posedge clk) disable iff (srst)
    req.valid && req.kind == pmem_pkg::ACC_WRITE && !unlocked |=> rsp.refused)
    else $error("write while locked");

  chk_beyond_array_refused: assert property (@(posedge clk) disable iff (srst)
    req.valid && (req.kind == pmem_pkg::ACC_WRITE || req.kind == pmem_pkg::ACC_ERASE)
    && req.addr >= 16'(pmem_pkg::ARRAY_BYTES) |=> rsp.refused)
    else $error("program beyond array accepted");

  // ----------------------------------------
  // Program
  // ----------------------------------------
  // Readback in the very next cycle must already show the bits the program cleared as zero
  chk_write_clears_only: assert property (@(posedge clk) disable iff (srst)
    s_program ##1 s_readback ##0 (req.addr == $past(req.addr))
    |=> (rsp.rdata & ~$past(req.wdata, 2)) == 8'h00)
    else $error("program did not clear bits");

  chk_debug_write_ok: assert property (@(posedge clk) disable iff (srst)
    (s_program and dbg_sel) |=> rsp.valid && !rsp.refused)
    else $error("debugger program refused");
endmodule

// >>> sim/core_model.sv
// Purpose: Core side issuing fetches, loads, programs and erases
// Assumes: One request at a time, answer one cycle after it is taken
// Notes: Released address is scrambled and valid dropped (issue also inverts data, pair does not), so stale values never look valid
`timescale 1ns/10ps
module core_model (
  input wire logic clk,
  input wire pmem_pkg::mem_rsp_t rsp,
  output pmem_pkg::mem_req_t req
);
  initial req = '0;
  task automatic issue(input pmem_pkg::acc_kind_t k, input logic [15:0] a,
                       input logic [7:0] d, output pmem_pkg::mem_rsp_t r);
    @(posedge clk);
    req <= '{valid: 1'b1, kind: k, addr: a, wdata: d};
    @(posedge clk);
    req <= '{valid: 1'b0, kind: k, addr: ~a, wdata: ~d};
    @(posedge clk);
    r = rsp;
  endtask
  // Program then read back in the very next cycle
  task automatic pair(input logic [15:0] a, input logic [7:0] d,
                      output pmem_pkg::mem_rsp_t r);
    @(posedge clk);
    req <= '{valid: 1'b1, kind: pmem_pkg::ACC_WRITE, addr: a, wdata: d};
    @(posedge clk);
    req <= '{valid: 1'b1, kind: pmem_pkg::ACC_LOAD, addr: a, wdata: ~d};
    @(posedge clk);
    req <= '{valid: 1'b0, kind: pmem_pkg::ACC_LOAD, addr: ~a, wdata: d};
    @(posedge clk);
    r = rsp;
  endtask
endmodule

// >>> sim/tb_top.sv
// Purpose: Self-checking bench for the program memory map
// Assumes: Array content undefined until a page is erased
// Notes: Control levels settle a few cycles before use
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic dbg_sel = 1'b0;
  logic unlocked = 1'b0;
  logic [7:0] page_sel = 8'h00;
  logic [7:0] sect_prot = 8'h00;
  logic [2:0] sector_idx;
  logic info_en;
  pmem_pkg::mem_req_t req;
  pmem_pkg::mem_rsp_t rsp;
  pmem_pkg::mem_rsp_t r;
  int err_total = 0;
  int checks_done = 0;
  integer seed = 32'h28b3af36;
  logic [15:0] a;
  logic [7:0] d;
  always #50 clk = ~clk;
  program_memory_map dut (.clk(clk), .srst(srst), .req(req), .dbg_sel(dbg_sel),
    .unlocked(unlocked), .page_sel(page_sel), .sect_prot(sect_prot), .rsp(rsp),
    .sector_idx(sector_idx), .info_en(info_en));
  core_model core (.clk(clk), .rsp(rsp), .req(req));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic go(input pmem_pkg::acc_kind_t k, input logic [15:0] x, input logic [7:0] v);
    core.issue(k, x, v, r);
  endtask
  task automatic idle();
    repeat (3) @(posedge clk);
  endtask
  // Reserved info bytes read as the package filler
  function automatic logic [7:0] info_byte(input logic [15:0] x);
    if (x < pmem_pkg::PART_ID_FIRST || x > pmem_pkg::PART_ID_LAST) return pmem_pkg::RESERVED_INFO;
    return pmem_pkg::PART_ID_TEXT[159 - 8 * (x - pmem_pkg::PART_ID_FIRST) -: 8];
  endfunction
  task automatic final_report();
    $display("mismatches %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    err_total++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    unlocked <= 1'b1;
    idle();
    chk({6'h00, rsp.valid, info_en}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      dbg_sel <= i[0];
      a = {2'b00, i[2:0], 11'($random(seed))};
      d = 8'($random(seed));
      go(pmem_pkg::ACC_ERASE, a, 8'h00);
      chk({7'h00, r.refused}, 8'h00);
      go(pmem_pkg::ACC_LOAD, a ^ 16'($random(seed) & 32'h1ff), 8'h00);
      chk(r.rdata, pmem_pkg::ERASED_BYTE);
      core.pair(a, d, r);
      chk(r.rdata, d);
      go(pmem_pkg::ACC_FETCH, a, 8'h00);
      chk(r.rdata, d);
      chk({5'h00, sector_idx}, {5'h00, i[2:0]});
      sect_prot <= 8'h01 << i;
      idle();
      go(pmem_pkg::ACC_WRITE, a, 8'h00);
      chk({7'h00, r.refused}, 8'h01);
      go(pmem_pkg::ACC_ERASE, a, 8'h00);
      chk({7'h00, r.refused}, 8'h01);
      go(pmem_pkg::ACC_LOAD, a, 8'h00);
      chk(r.rdata, d);
      sect_prot <= 8'h00;
      unlocked <= 1'b0;
      go(pmem_pkg::ACC_WRITE, a, 8'h00);
      chk({7'h00, r.refused}, 8'h01);
      go(pmem_pkg::ACC_FETCH, a, 8'h00);
      chk(r.rdata, d);
      unlocked <= 1'b1;
    end
    page_sel <= 8'h80;
    idle();
    chk({7'h00, info_en}, 8'h01);
    for (int j = 0; j < 48; j++) begin
      a = (j < 40) ? 16'hfe30 + 16'(j) : 16'hfe00 | 16'($random(seed) & 32'h1ff);
      go(pmem_pkg::ACC_WRITE, a, 8'h00);
      chk({7'h00, r.refused}, 8'h01);
      go(pmem_pkg::ACC_LOAD, a, 8'h00);
      chk(r.rdata, info_byte(a));
      go(pmem_pkg::ACC_FETCH, a, 8'h00);
      chk(r.rdata, pmem_pkg::ERASED_BYTE);
    end
    page_sel <= 8'h00;
    idle();
    go(pmem_pkg::ACC_LOAD, pmem_pkg::PART_ID_FIRST, 8'h00);
    chk({7'h00, info_en}, 8'h00);
    chk(r.rdata, pmem_pkg::ERASED_BYTE);
    final_report();
  end
endmodule
